// ==== hdl/sc_defines.svh ====
// offsets, field positions and reset values of the system control registers
`ifndef SC_DEFINES_SVH
`define SC_DEFINES_SVH
// ****************************************
// address map (byte addresses, one word each except the fault status byte and halfword views)
// ****************************************
`define SC_WINDOW_BASE 32'he000e000
`define SC_AUXCTL_ADDR 32'he000e008
`define SC_COREID_ADDR 32'he000ed00
`define SC_ICSR_ADDR 32'he000ed04
`define SC_VTOR_ADDR 32'he000ed08
`define SC_CFSR_ADDR 32'he000ed28
`define SC_MEMMANAGE_FAULT_STATUS_ADDR 32'he000ed28
`define SC_BUS_FAULT_STATUS_ADDR 32'he000ed29
`define SC_USAGE_FAULT_STATUS_ADDR 32'he000ed2a
`define SC_MMADDR_ADDR 32'he000ed34
`define SC_BFADDR_ADDR 32'he000ed38
// ****************************************
// auxiliary control bits
// ****************************************
`define SC_AUX_MCYC 0
`define SC_AUX_WBUF 1
`define SC_AUX_FOLD 2
`define SC_AUX_FPCA 8
`define SC_AUX_OOOF 9
// ****************************************
// interrupt control and state fields
// ****************************************
`define SC_ICSR_NMISET 31
`define SC_ICSR_SVSET 28
`define SC_ICSR_SVCLR 27
`define SC_ICSR_STSET 26
`define SC_ICSR_STCLR 25
`define SC_ICSR_IRQPEND 22
`define SC_ICSR_PVEC_LSB 12
`define SC_ICSR_RTB 11
// ****************************************
// fault status, table offset and identification constant fields
// ****************************************
`define SC_CFSR_MMVALID 7
`define SC_CFSR_BFVALID 15
`define SC_VTOR_LSB 7
`define SC_ID_CONST 4'hf
// ****************************************
// reset values
// ****************************************
`define SC_AUXCTL_RST 5'h00
`define SC_VTOR_RST 23'h000000
`define SC_CFSR_RST 32'h00000000
`define SC_FADDR_RST 32'h00000000
`endif

// ==== hdl/sc_pkg.sv ====
// types shared by the system control register block and its bus controller
package sc_pkg;
    // device end state
    typedef struct packed {
        logic no_out_of_order_float;
        logic no_float_context_update;
        logic fold_disable;
        logic default_write_buffer_off;
        logic multicycle_interrupt_off;
        logic [22:0] table_offset_field;
        logic [31:0] cfsr;
        logic [31:0] memfault_address;
        logic [31:0] busfault_address;
        logic nmi_prev;
        logic ack;
        logic err;
        logic [31:0] rdata;
    } dev_state_t;

    // single pending flag
    typedef struct packed {
        logic flag;
    } flag_state_t;

    // controller sequencing
    typedef enum logic [2:0] {
        C_IDLE = 3'b001,
        C_BUSY = 3'b010,
        C_RESP = 3'b100
    } ctl_phase_t;

    typedef struct packed {
        ctl_phase_t phase;
        logic aw_held;
        logic w_held;
        logic [31:0] addr;
        logic [31:0] wdata;
        logic [3:0] be;
        logic is_wr;
        logic req;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
    } ctl_state_t;
endpackage

// ==== hdl/sc_link_if.sv ====
// register link between the bus controller and the system control block
interface sc_link_if;
    logic req;
    logic wr;
    logic [31:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
    logic ack;
    logic err;
    logic [31:0] rdata;

    modport dev (input req, input wr, input addr, input be, input wdata,
                 output ack, output err, output rdata);
    modport ctl (output req, output wr, output addr, output be, output wdata,
                 input ack, input err, input rdata);
endinterface

// ==== hdl/pend_flag.sv ====
// one pending bit, where a set always beats a clear in the same cycle
module pend_flag
    import sc_pkg::*;
(
    // clock and reset
    input wire logic CLK,
    input wire logic RSTN,
    // control
    input wire logic set,
    input wire logic clr,
    // state
    output logic q
);
    flag_state_t st_q;
    flag_state_t st_d;

    // set wins so an event coincident with a clear is not lost
    always_comb begin
        st_d = st_q;
        if (set) begin
            st_d.flag = 1'b1;
        end else if (clr) begin
            st_d.flag = 1'b0;
        end
    end

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign q = st_q.flag;
endmodule

// ==== hdl/sc_regs.sv ====
// system control register block: controls, ident, pending bits, fault status
// Functional notes
// [RULE1] software uses word accesses, fault status also narrower
// [RULE2] unaligned or wrong-size accesses are refused
// [RULE3] fault address trusted only while valid flag set
// [RULE4] fault status split into byte, byte, halfword
// [RULE5] fold disable stops if-then block overlap
// [RULE6] write buffer off makes stores complete in order
// [RULE7] multicycle interrupt off lets load/store-multiple finish
// [RULE8] float ordering and context flag update disables
// [RULE9] identification read-only, constant field reads 0xf
// [RULE10] nonmaskable set-pending: write one pends, reads state
// [RULE11] handler entry clears; reassertion sets it again
// [RULE12] service call pended only by software set
// [RULE13] service call clear bit removes pending
// [RULE14] tick set-pending: write one pends, reads state
// [RULE15] tick clear bit is write-only, removes pending
// [RULE16] never set and clear same exception together
// [RULE17] irq pending flag excludes nonmaskable and faults
// [RULE18] pending vector: zero or highest enabled pending
// [RULE19] return-to-base reads zero when preempted exceptions remain
// [RULE20] active vector equals program status bits 8:0
// [RULE21] table offset holds bits 29:7, bit 29 region
// [RULE22] table offset bits 6:0 always zero
// [RULE23] reserved bits read zero, writes ignored
`include "sc_defines.svh"
module sc_regs
    import sc_pkg::*;
#(
    parameter logic [7:0] IMPLEMENTER = 8'h5a,  // arbitrary value
    parameter logic [3:0] VARIANT = 4'h1,       // arbitrary value
    parameter logic [11:0] PART_NUMBER = 12'h123, // arbitrary value
    parameter logic [3:0] REVISION = 4'h2       // arbitrary value
)
(
    // clock and reset
    input wire logic CLK,
    input wire logic RSTN,
    // register link
    sc_link_if.dev link,
    // core exception state
    input wire logic NMI_IN,
    input wire logic NMI_ENTER,
    input wire logic PENDABLE_SERVICE_CALL_ENTER,
    input wire logic TICK_EVENT,
    input wire logic TICK_ENTER,
    input wire logic IRQ_PENDING_IN,
    input wire logic [8:0] PENDING_VECTOR_IN,
    input wire logic [8:0] ACTIVE_VECTOR_IN,
    input wire logic PREEMPTED_IN,
    // fault capture
    input wire logic MM_FAULT,
    input wire logic [6:0] MM_FAULT_BITS,
    input wire logic MM_ADDR_VALID,
    input wire logic [31:0] MM_ADDR,
    input wire logic BUS_FAULT,
    input wire logic [6:0] BUS_FAULT_BITS,
    input wire logic BUS_ADDR_VALID,
    input wire logic [31:0] BUS_ADDR,
    input wire logic USAGE_FAULT,
    input wire logic [15:0] USAGE_FAULT_BITS,
    // controls to the core
    output logic FOLD_DISABLE,
    output logic WRITE_BUFFER_OFF,
    output logic MULTICYCLE_INT_OFF,
    output logic NO_OOO_FLOAT,
    output logic NO_FPCA_UPDATE,
    output logic NMI_PENDING,
    output logic PENDABLE_SERVICE_CALL_PENDING,
    output logic TICK_PENDING,
    output logic [31:0] VECTOR_TABLE_BASE
);
    dev_state_t st_q;
    dev_state_t st_d;
    logic [31:0] word_addr;
    logic sel_aux;
    logic sel_id;
    logic sel_icsr;
    logic sel_vtor;
    logic sel_cfsr;
    logic sel_mma;
    logic sel_bfa;
    logic be_word;
    logic be_narrow;
    logic legal;
    logic wr_ok;
    logic [31:0] be_mask;
    logic icsr_wr;
    logic nmi_set;
    logic sv_set;
    logic sv_clr;
    logic st_set;
    logic st_clr;
    logic [31:0] rd_word;
    logic [31:0] cfsr_set;

    // ****************************************
    // address decode and access checks
    // ****************************************
    assign word_addr = {link.addr[31:2], 2'b00};
    assign sel_aux = (word_addr == `SC_AUXCTL_ADDR);
    assign sel_id = (word_addr == `SC_COREID_ADDR);
    assign sel_icsr = (word_addr == `SC_ICSR_ADDR);
    assign sel_vtor = (word_addr == `SC_VTOR_ADDR);
    assign sel_cfsr = (word_addr == `SC_CFSR_ADDR);
    assign sel_mma = (word_addr == `SC_MMADDR_ADDR);
    assign sel_bfa = (word_addr == `SC_BFADDR_ADDR);
    assign be_word = (link.be == 4'hf);
    // byte or aligned halfword lanes; a halfword across lanes 1-2 is unaligned
    assign be_narrow = (link.be == 4'h1) || (link.be == 4'h2) || (link.be == 4'h4) ||
                       (link.be == 4'h8) || (link.be == 4'h3) || (link.be == 4'hc);
    // narrow accesses only to fault status, other registers whole words, unmapped addresses refused
    assign legal = (sel_aux || sel_id || sel_icsr || sel_vtor || sel_mma || sel_bfa)
                   ? be_word
                   : (sel_cfsr && (be_word || be_narrow)); // RULE1 RULE2 RULE4
    assign wr_ok = link.req && link.wr && legal;
    assign be_mask = {{8{link.be[3]}}, {8{link.be[2]}}, {8{link.be[1]}}, {8{link.be[0]}}};

    // ****************************************
    // pending bits
    // ****************************************
    assign icsr_wr = wr_ok && sel_icsr;
    // rising nonmaskable input re-pends even inside its own handler
    assign nmi_set = (icsr_wr && link.wdata[`SC_ICSR_NMISET]) ||
                     (NMI_IN && !st_q.nmi_prev); // RULE10 RULE11
    assign sv_set = icsr_wr && link.wdata[`SC_ICSR_SVSET]; // RULE12
    assign sv_clr = (icsr_wr && link.wdata[`SC_ICSR_SVCLR]) || PENDABLE_SERVICE_CALL_ENTER; // RULE13
    assign st_set = (icsr_wr && link.wdata[`SC_ICSR_STSET]) || TICK_EVENT; // RULE14
    assign st_clr = (icsr_wr && link.wdata[`SC_ICSR_STCLR]) || TICK_ENTER; // RULE15

    // set and clear together resolve as set; software must not rely on it
    pend_flag u_nmi_pend (
        .CLK(CLK),
        .RSTN(RSTN),
        .set(nmi_set),
        .clr(NMI_ENTER), // RULE11
        .q(NMI_PENDING)
    );

    pend_flag u_sv_pend (
        .CLK(CLK),
        .RSTN(RSTN),
        .set(sv_set),
        .clr(sv_clr), // RULE16
        .q(PENDABLE_SERVICE_CALL_PENDING)
    );

    pend_flag u_tick_pend (
        .CLK(CLK),
        .RSTN(RSTN),
        .set(st_set),
        .clr(st_clr), // RULE16
        .q(TICK_PENDING)
    );

    // ****************************************
    // fault status events
    // ****************************************
    assign cfsr_set = {
        USAGE_FAULT ? USAGE_FAULT_BITS : 16'h0000,
        BUS_FAULT && BUS_ADDR_VALID, BUS_FAULT ? BUS_FAULT_BITS : 7'h00,
        MM_FAULT && MM_ADDR_VALID, MM_FAULT ? MM_FAULT_BITS : 7'h00
    }; // RULE4

    // ****************************************
    // read data
    // ****************************************
    always_comb begin
        rd_word = 32'h00000000; // RULE23
        if (sel_aux) begin
            rd_word[`SC_AUX_MCYC] = st_q.multicycle_interrupt_off;
            rd_word[`SC_AUX_WBUF] = st_q.default_write_buffer_off;
            rd_word[`SC_AUX_FOLD] = st_q.fold_disable;
            rd_word[`SC_AUX_FPCA] = st_q.no_float_context_update;
            rd_word[`SC_AUX_OOOF] = st_q.no_out_of_order_float;
        end else if (sel_id) begin
            rd_word = {IMPLEMENTER, VARIANT, `SC_ID_CONST, PART_NUMBER, REVISION}; // RULE9
        end else if (sel_icsr) begin
            // both clear bits read zero; they hold no state
            rd_word[`SC_ICSR_NMISET] = NMI_PENDING; // RULE10
            rd_word[`SC_ICSR_SVSET] = PENDABLE_SERVICE_CALL_PENDING; // RULE12
            rd_word[`SC_ICSR_STSET] = TICK_PENDING; // RULE14 RULE15
            rd_word[`SC_ICSR_IRQPEND] = IRQ_PENDING_IN; // RULE17
            // masking by base priority and fault mask is done in the core
            rd_word[`SC_ICSR_PVEC_LSB +: 9] = PENDING_VECTOR_IN; // RULE18
            rd_word[`SC_ICSR_RTB] = (ACTIVE_VECTOR_IN == 9'h000) || !PREEMPTED_IN; // RULE19
            rd_word[8:0] = ACTIVE_VECTOR_IN; // RULE20
        end else if (sel_vtor) begin
            rd_word[29:`SC_VTOR_LSB] = st_q.table_offset_field; // RULE21 RULE22
        end else if (sel_cfsr) begin
            rd_word = st_q.cfsr;
        end else if (sel_mma) begin
            rd_word = st_q.memfault_address; // RULE3
        end else if (sel_bfa) begin
            rd_word = st_q.busfault_address; // RULE3
        end
    end

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        st_d = st_q;
        st_d.ack = link.req;
        st_d.err = link.req && !legal; // RULE2
        st_d.nmi_prev = NMI_IN;
        if (link.req && !link.wr) begin
            st_d.rdata = legal ? rd_word : 32'h00000000;
        end
        if (wr_ok && sel_aux) begin
            st_d.multicycle_interrupt_off = link.wdata[`SC_AUX_MCYC]; // RULE7
            st_d.default_write_buffer_off = link.wdata[`SC_AUX_WBUF]; // RULE6
            st_d.fold_disable = link.wdata[`SC_AUX_FOLD]; // RULE5
            st_d.no_float_context_update = link.wdata[`SC_AUX_FPCA]; // RULE8
            st_d.no_out_of_order_float = link.wdata[`SC_AUX_OOOF]; // RULE8
        end
        if (wr_ok && sel_vtor) begin
            st_d.table_offset_field = link.wdata[29:`SC_VTOR_LSB]; // RULE21 RULE22
        end
        // write-one-to-clear on the enabled lanes, then new faults win
        if (wr_ok && sel_cfsr) begin
            st_d.cfsr = st_q.cfsr & ~(link.wdata & be_mask);
        end
        st_d.cfsr = st_d.cfsr | cfsr_set;
        // a later fault simply overwrites the captured address
        if (MM_FAULT && MM_ADDR_VALID) begin
            st_d.memfault_address = MM_ADDR; // RULE3
        end
        if (BUS_FAULT && BUS_ADDR_VALID) begin
            st_d.busfault_address = BUS_ADDR; // RULE3
        end
    end

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            st_q <= '0;
            {st_q.no_out_of_order_float, st_q.no_float_context_update, st_q.fold_disable,
             st_q.default_write_buffer_off, st_q.multicycle_interrupt_off} <= `SC_AUXCTL_RST;
            st_q.table_offset_field <= `SC_VTOR_RST;
            st_q.cfsr <= `SC_CFSR_RST;
            st_q.memfault_address <= `SC_FADDR_RST;
            st_q.busfault_address <= `SC_FADDR_RST;
        end else begin
            st_q <= st_d;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign link.ack = st_q.ack;
    assign link.err = st_q.err;
    assign link.rdata = st_q.rdata;
    assign FOLD_DISABLE = st_q.fold_disable; // RULE5
    assign WRITE_BUFFER_OFF = st_q.default_write_buffer_off; // RULE6
    assign MULTICYCLE_INT_OFF = st_q.multicycle_interrupt_off; // RULE7
    assign NO_OOO_FLOAT = st_q.no_out_of_order_float; // RULE8
    assign NO_FPCA_UPDATE = st_q.no_float_context_update; // RULE8
    assign VECTOR_TABLE_BASE = {2'b00, st_q.table_offset_field, 7'h00}; // RULE22
endmodule

// ==== hdl/sc_axi_ctrl.sv ====
// AXI4-Lite slave that forwards software accesses onto the register link
`include "sc_defines.svh"
module sc_axi_ctrl
    import sc_pkg::*;
(
    // clock and reset
    input wire logic CLK,
    input wire logic RSTN,
    // write address channel
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [11:0] AWADDR,
    // write data channel
    input wire logic WVALID,
    output logic WREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    // write response channel
    output logic BVALID,
    input wire logic BREADY,
    output logic [1:0] BRESP,
    // read address channel
    input wire logic ARVALID,
    output logic ARREADY,
    input wire logic [11:0] ARADDR,
    // read data channel
    output logic RVALID,
    input wire logic RREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    // register link
    sc_link_if.ctl link
);
    ctl_state_t st_q;
    ctl_state_t st_d;
    logic idle;

    assign idle = (st_q.phase == C_IDLE);
    assign AWREADY = !st_q.aw_held;
    assign WREADY = !st_q.w_held;
    // reads wait for any held or offered write, so addr and lanes stay intact
    assign ARREADY = idle && !st_q.aw_held && !st_q.w_held && !AWVALID && !WVALID;

    // ****************************************
    // sequencing
    // ****************************************
    always_comb begin
        st_d = st_q;
        st_d.req = 1'b0;
        if (AWVALID && !st_q.aw_held) begin
            st_d.aw_held = 1'b1;
            st_d.addr = `SC_WINDOW_BASE | {20'h00000, AWADDR[11:2], 2'b00};
        end
        if (WVALID && !st_q.w_held) begin
            st_d.w_held = 1'b1;
            st_d.wdata = WDATA;
            st_d.be = WSTRB; // RULE1
        end
        case (st_q.phase)
            C_IDLE: begin
                if (st_q.aw_held && st_q.w_held) begin
                    st_d.is_wr = 1'b1;
                    st_d.req = 1'b1;
                    st_d.phase = C_BUSY;
                end else if (ARVALID && ARREADY) begin
                    st_d.is_wr = 1'b0;
                    st_d.addr = `SC_WINDOW_BASE | {20'h00000, ARADDR[11:2], 2'b00};
                    st_d.be = 4'hf;
                    st_d.req = 1'b1;
                    st_d.phase = C_BUSY;
                end
            end
            C_BUSY: begin
                if (link.ack) begin
                    if (st_q.is_wr) begin
                        st_d.bvalid = 1'b1;
                        st_d.bresp = link.err ? 2'b10 : 2'b00;
                    end else begin
                        st_d.rvalid = 1'b1;
                        st_d.rresp = link.err ? 2'b10 : 2'b00;
                        st_d.rdata = link.rdata;
                    end
                    st_d.phase = C_RESP;
                end
            end
            C_RESP: begin
                if (st_q.bvalid && BREADY) begin
                    st_d.bvalid = 1'b0;
                    st_d.aw_held = 1'b0;
                    st_d.w_held = 1'b0;
                    st_d.phase = C_IDLE;
                end else if (st_q.rvalid && RREADY) begin
                    st_d.rvalid = 1'b0;
                    st_d.phase = C_IDLE;
                end
            end
            default: begin
                st_d.phase = C_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            st_q <= '0;
            st_q.phase <= C_IDLE;
        end else begin
            st_q <= st_d;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign link.req = st_q.req;
    assign link.wr = st_q.is_wr;
    assign link.addr = st_q.addr;
    assign link.be = st_q.be;
    assign link.wdata = st_q.wdata;
    assign BVALID = st_q.bvalid;
    assign BRESP = st_q.bresp;
    assign RVALID = st_q.rvalid;
    assign RRESP = st_q.rresp;
    assign RDATA = st_q.rdata;
endmodule

// ==== verif/sc_link_chk.sv ====
// concurrent checks on the register link between the controller and the block
`include "sc_defines.svh"
module sc_link_chk (
    // clock and reset
    input wire logic CLK,
    input wire logic RSTN,
    // link request
    input wire logic req,
    input wire logic wr,
    input wire logic [31:0] addr,
    input wire logic [3:0] be,
    // link answer
    input wire logic ack,
    input wire logic err,
    input wire logic [31:0] rdata
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RSTN);
    logic rd_req;
    logic word_only;
    // ****************************************
    // request decode
    // ****************************************
    // aux, ident, icsr and table offset registers refuse any narrower lane set
    assign rd_req = req && !wr;
    assign word_only = addr == `SC_AUXCTL_ADDR || addr == `SC_COREID_ADDR
        || addr == `SC_ICSR_ADDR || addr == `SC_VTOR_ADDR;
    // ****************************************
    // link properties
    // ****************************************
    a_answer_next: assert property (req |=> ack ##1 !ack)
        else $error("link answer late or long");
    a_answer_cause: assert property (ack |-> $past(req))
        else $error("link answer without request");
    a_refusal_ack: assert property (err |-> ack)
        else $error("refusal outside an answer");
    a_word_lanes: assert property (req && word_only && be != 4'hf |=> err)
        else $error("narrow access to word register taken");
    a_fault_lanes: assert property (req && addr == `SC_CFSR_ADDR |=>
        err == !($past(be) inside {4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hc, 4'hf}))
        else $error("fault status lane decision wrong");
    a_ident_const: assert property (rd_req && addr == `SC_COREID_ADDR |=>
        rdata[19:16] == 4'hf) else $error("ident constant field wrong");
    a_table_zero: assert property (rd_req && addr == `SC_VTOR_ADDR |=>
        rdata[6:0] == 7'h00) else $error("table offset low bits set");
    a_clear_bits: assert property (rd_req && addr == `SC_ICSR_ADDR |=>
        !rdata[27] && !rdata[25]) else $error("clear bits read back");
    a_aux_spare: assert property (rd_req && addr == `SC_AUXCTL_ADDR |=>
        rdata[31:10] == 22'h0 && rdata[7:3] == 5'h00) else $error("aux spare bits set");
    c_icsr_write: cover property (req && wr && addr == `SC_ICSR_ADDR);
    c_fault_byte: cover property (req && addr == `SC_CFSR_ADDR && be == 4'h2);
    c_refused: cover property (ack && err);
endmodule

// ==== verif/system_control_exception_regs_bench.sv ====
// self-checking bench: bus controller and register block joined over the link
module system_control_exception_regs_bench;
    timeunit 1ns;
    timeprecision 1ns;
    // ****************************************
    // signals
    // ****************************************
    logic CLK = 1'b0;
    logic RSTN = 1'b0;
    logic AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0, ARVALID = 1'b0, RREADY = 1'b0;
    logic [11:0] AWADDR = 12'h000, ARADDR = 12'h000;
    logic [31:0] WDATA = 32'h0, RDATA, VECTOR_TABLE_BASE, rd;
    logic [3:0] WSTRB = 4'h0;
    logic [1:0] BRESP, RRESP, rs;
    logic AWREADY, WREADY, BVALID, ARREADY, RVALID;
    logic NMI_IN = 1'b0, NMI_ENTER = 1'b0, PENDABLE_SERVICE_CALL_ENTER = 1'b0, TICK_EVENT = 1'b0;
    logic TICK_ENTER = 1'b0, IRQ_PENDING_IN = 1'b0, PREEMPTED_IN = 1'b0;
    logic [8:0] PENDING_VECTOR_IN = 9'h000, ACTIVE_VECTOR_IN = 9'h000;
    logic MM_FAULT = 1'b0, MM_ADDR_VALID = 1'b0, BUS_FAULT = 1'b0, BUS_ADDR_VALID = 1'b0;
    logic USAGE_FAULT = 1'b0;
    logic [6:0] MM_FAULT_BITS = 7'h00, BUS_FAULT_BITS = 7'h00;
    logic [15:0] USAGE_FAULT_BITS = 16'h0000;
    logic [31:0] MM_ADDR = 32'h0, BUS_ADDR = 32'h0;
    logic FOLD_DISABLE, WRITE_BUFFER_OFF, MULTICYCLE_INT_OFF, NO_OOO_FLOAT, NO_FPCA_UPDATE;
    logic NMI_PENDING, PENDABLE_SERVICE_CALL_PENDING, TICK_PENDING;
    int fails = 0;
    int n_checks = 0;
    int cyc = 0;
    sc_link_if i_sc_link_if ();
    sc_axi_ctrl i_sc_axi_ctrl (.link(i_sc_link_if), .*);
    sc_regs i_sc_regs (.link(i_sc_link_if), .*);
    sc_link_chk i_sc_link_chk (.CLK, .RSTN, .req(i_sc_link_if.req), .wr(i_sc_link_if.wr),
        .addr(i_sc_link_if.addr), .be(i_sc_link_if.be), .ack(i_sc_link_if.ack),
        .err(i_sc_link_if.err), .rdata(i_sc_link_if.rdata));
    always #25 CLK = ~CLK;
    // hang guard: the whole run needs well under a thousand cycles
    always @(posedge CLK) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            fails++;
            wrap_up();
        end
    end
    // ****************************************
    // helpers
    // ****************************************
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    function automatic logic [31:0] pend();
        return {29'h0, NMI_PENDING, PENDABLE_SERVICE_CALL_PENDING, TICK_PENDING};
    endfunction
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        logic b;
        AWADDR <= a;
        WDATA <= d;
        WSTRB <= s;
        AWVALID <= 1'b1;
        WVALID <= 1'b1;
        BREADY <= 1'b1;
        b = 1'b0;
        while (!b) begin
            @(posedge CLK);
            if (AWREADY) AWVALID <= 1'b0;
            if (WREADY) WVALID <= 1'b0;
            b = BVALID;
            rs = BRESP;
        end
        BREADY <= 1'b0;
        @(posedge CLK);
    endtask
    task automatic rdr(input logic [11:0] a);
        logic v;
        ARADDR <= a;
        ARVALID <= 1'b1;
        RREADY <= 1'b1;
        v = 1'b0;
        while (!v) begin
            @(posedge CLK);
            if (ARREADY) ARVALID <= 1'b0;
            v = RVALID;
            rd = RDATA;
            rs = RRESP;
        end
        RREADY <= 1'b0;
        @(posedge CLK);
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_aux();
        rdr(12'h008);
        chk("aux reset", 32'h0, rd);
        wr(12'h008, 32'hffff_ffff, 4'hf);
        rdr(12'h008);
        chk("aux read", 32'h0000_0307, rd);
        chk("aux outs set", 32'h3, {30'h0, WRITE_BUFFER_OFF, MULTICYCLE_INT_OFF});
        wr(12'h008, 32'h0000_0104, 4'hf);
        wr(12'h008, 32'h0, 4'h1);
        chk("aux narrow resp", 32'h2, {30'h0, rs});
        chk("aux outs", 32'h0c, {27'h0, NO_OOO_FLOAT, NO_FPCA_UPDATE, FOLD_DISABLE,
            WRITE_BUFFER_OFF, MULTICYCLE_INT_OFF});
        rdr(12'hd00);
        chk("ident", 32'h5a1f_1232, rd);
        wr(12'hd00, 32'h0, 4'hf);
        rdr(12'hd00);
        chk("ident kept", 32'h5a1f_1232, rd);
        rdr(12'h100);
        chk("unmapped resp", 32'h2, {30'h0, rs});
        $display("aux and ident test done");
    endtask
    task automatic t_pend();
        wr(12'hd04, 32'h8000_0000, 4'hf);
        rdr(12'hd04);
        chk("icsr nmi", 32'h8000_0800, rd);
        NMI_ENTER <= 1'b1;
        @(posedge CLK);
        NMI_ENTER <= 1'b0;
        NMI_IN <= 1'b1;
        repeat (3) @(posedge CLK);
        wr(12'hd04, 32'h0, 4'hf);
        chk("nmi reasserted", 32'h4, pend());
        NMI_ENTER <= 1'b1;
        @(posedge CLK);
        NMI_ENTER <= 1'b0;
        wr(12'hd04, 32'h1000_0000, 4'hf);
        chk("service set", 32'h2, pend());
        wr(12'hd04, 32'h0800_0000, 4'hf);
        wr(12'hd04, 32'h0400_0000, 4'hf);
        rdr(12'hd04);
        chk("icsr tick", 32'h0400_0800, rd);
        wr(12'hd04, 32'h0200_0000, 4'hf);
        chk("all clear", 32'h0, pend());
        TICK_EVENT <= 1'b1;
        @(posedge CLK);
        TICK_EVENT <= 1'b0;
        repeat (2) @(posedge CLK);
        chk("tick event", 32'h1, pend());
        $display("pending test done");
    endtask
    task automatic t_state();
        IRQ_PENDING_IN <= 1'b1;
        PENDING_VECTOR_IN <= 9'h02b;
        ACTIVE_VECTOR_IN <= 9'h013;
        PREEMPTED_IN <= 1'b1;
        rdr(12'hd04);
        chk("icsr state", 32'h0442_b013, rd);
        PREEMPTED_IN <= 1'b0;
        TICK_ENTER <= 1'b1;
        rdr(12'hd04);
        chk("icsr base", 32'h0042_b813, rd);
        TICK_ENTER <= 1'b0;
        wr(12'hd08, 32'hffff_ffff, 4'hf);
        rdr(12'hd08);
        chk("table offset", 32'h3fff_ff80, rd);
        chk("table base", 32'h3fff_ff80, VECTOR_TABLE_BASE);
        $display("state test done");
    endtask
    task automatic t_fault();
        {MM_FAULT, MM_ADDR_VALID, BUS_FAULT, BUS_ADDR_VALID, USAGE_FAULT} <= 5'h1f;
        MM_FAULT_BITS <= 7'h05;
        BUS_FAULT_BITS <= 7'h02;
        USAGE_FAULT_BITS <= 16'h0100;
        MM_ADDR <= 32'h2000_1234;
        @(posedge CLK);
        {MM_FAULT, MM_ADDR_VALID, BUS_FAULT, BUS_ADDR_VALID, USAGE_FAULT} <= 5'h00;
        rdr(12'hd34);
        chk("fault address", 32'h2000_1234, rd);
        rdr(12'hd28);
        chk("fault status", 32'h0100_8285, rd);
        wr(12'hd29, 32'h0000_8000, 4'h2);
        wr(12'hd2a, 32'hffff_0000, 4'hc);
        wr(12'hd28, 32'hffff_ffff, 4'h6);
        chk("odd lanes resp", 32'h2, {30'h0, rs});
        rdr(12'hd28);
        chk("after clears", 32'h0000_0285, rd);
        $display("fault test done");
    endtask
    initial begin
        repeat (4) @(posedge CLK);
        RSTN <= 1'b1;
        @(posedge CLK);
        t_aux();
        t_pend();
        t_state();
        t_fault();
        wrap_up();
    end
endmodule
